// ### verilog/pss_status_summary.sv
/*
 Transceiver status summary register bank behind an AXI4-Lite slave.
 Latches and mirrors status from the receive, carrier, polarity,
 descrambler and negotiation units, and the read-clear words of those
 units are decoded here so that their reads clear the mirrors.
 Assumes status inputs synchronous to REF_CLK_I and one outstanding
 read and one outstanding write from the bus master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"

// Contract
// - Bits 15 and 7 read zero, writes ignored
// - Bit 14 is one when pairs swapped
// - Bit 14 follows enable, force and algorithm
// - Bit 13 latches receive error, cleared 15h read
// - Bit 12 latches inverted polarity status
// - Bit 12 clears on ten-meg read only
// - Bit 11 latches false carrier, cleared 14h read
// - Bit 10 qualified signal detect per 16h bit 8
// - Bit 9 descrambler lock, latch-low, default zero
// - Bit 8 page received, cleared 06h read
// - Bit 6 remote fault, cleared 01h read
// - Word at 10h, upper bits reset zero
module pss_status_summary (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    // AXI4-Lite write address
    input wire logic [7:0] S_AWADDR_I,
    input wire logic S_AWVALID_I,
    output logic S_AWREADY_O,
    // AXI4-Lite write data
    input wire logic [31:0] S_WDATA_I,
    input wire logic [3:0] S_WSTRB_I,
    input wire logic S_WVALID_I,
    output logic S_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0] S_BRESP_O,
    output logic S_BVALID_O,
    input wire logic S_BREADY_I,
    // AXI4-Lite read address
    input wire logic [7:0] S_ARADDR_I,
    input wire logic S_ARVALID_I,
    output logic S_ARREADY_O,
    // AXI4-Lite read data
    output logic [31:0] S_RDATA_O,
    output logic [1:0] S_RRESP_O,
    output logic S_RVALID_O,
    input wire logic S_RREADY_I,
    // Status from the source units
    input wire logic MDIX_SWAP_I,
    input wire logic RX_ERROR_EVENT_I,
    input wire logic POLARITY_INVERTED_I,
    input wire logic FALSE_CARRIER_EVENT_I,
    input wire logic SIGNAL_DETECT_RAW_I,
    input wire logic DESCRAMBLER_LOCK_I,
    input wire logic PAGE_RECEIVED_EVENT_I,
    input wire logic REMOTE_FAULT_EVENT_I,
    // Words of the source units, returned on their reads
    input wire logic [15:0] BASIC_STATUS_WORD_I,
    input wire logic [15:0] EXPANSION_WORD_I,
    input wire logic [15:0] FALSE_CARRIER_COUNT_WORD_I,
    input wire logic [15:0] RX_ERROR_COUNT_WORD_I,
    input wire logic [15:0] TEN_MEG_STATUS_WORD_I,
    // Settings handed to the pair mux and link monitor
    output logic AUTO_CROSSOVER_ENABLE_O,
    output logic CROSSOVER_FORCE_O,
    output logic SD_QUALIFY_O
);

    // Write side holding registers
    pss_pkg::pss_idx_t aw_idx; // Captured write index
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb; // Captured byte strobes
    logic wr_fire; // Both halves held, commit now
    logic wr_mapped; // Index is in the map

    // Read side
    logic rd_take; // Read address handshake
    pss_pkg::pss_idx_t rd_idx; // Index of that read
    pss_pkg::pss_word_t next_rdata; // Word to return
    pss_pkg::pss_resp_t next_rresp; // Response to return

    // Read-clear strobes, one per source word
    logic clr_basic;
    logic clr_expansion;
    logic clr_false_carrier;
    logic clr_rx_error;
    logic clr_ten_meg;
    logic rd_summary; // Summary read, reloads latch-low bits

    // Status bits of the summary word
    logic crossover;
    logic rx_error;
    logic polarity;
    logic false_carrier;
    logic signal_detect;
    logic lock;
    logic page;
    logic remote_fault;
    logic sd_qualified; // Detect as the link monitor sees it
    pss_pkg::pss_word_t summary; // Assembled word

    // Commit only once both halves are in and no response waits
    assign wr_fire = !S_AWREADY_O && !S_WREADY_O && !S_BVALID_O;
    assign rd_take = S_ARVALID_I && S_ARREADY_O;
    assign rd_idx = S_ARADDR_I[7:2];

    // Clears fire on the read handshake, after the value is sampled
    assign clr_basic = rd_take && (rd_idx == `PSS_IDX_BASIC_STATUS);
    assign clr_expansion = rd_take && (rd_idx == `PSS_IDX_EXPANSION);
    assign clr_false_carrier = rd_take && (rd_idx == `PSS_IDX_FALSE_CARRIER);
    assign clr_rx_error = rd_take && (rd_idx == `PSS_IDX_RX_ERROR);
    assign clr_ten_meg = rd_take && (rd_idx == `PSS_IDX_TEN_MEG);
    assign rd_summary = rd_take && (rd_idx == `PSS_IDX_SUMMARY);

    // Qualified detect: lock gating unless software clears SD_QUALIFY_O
    assign sd_qualified = SD_QUALIFY_O ?
        (SIGNAL_DETECT_RAW_I && DESCRAMBLER_LOCK_I) : SIGNAL_DETECT_RAW_I;

    // Summary word; reserved and low bits are constant zero
    always_comb begin
        summary = 16'h0000;
        summary[`PSS_BIT_CROSSOVER] = crossover;
        summary[`PSS_BIT_RX_ERROR] = rx_error;
        summary[`PSS_BIT_POLARITY] = polarity;
        summary[`PSS_BIT_FALSE_CARRIER] = false_carrier;
        summary[`PSS_BIT_SIGNAL_DETECT] = signal_detect;
        summary[`PSS_BIT_LOCK] = lock;
        summary[`PSS_BIT_PAGE] = page;
        summary[`PSS_BIT_REMOTE_FAULT] = remote_fault;
    end

    // Write address channel
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AWREADY_O <= 1'b1;
            aw_idx <= 6'h00;
        end else if (S_AWVALID_I && S_AWREADY_O) begin
            S_AWREADY_O <= 1'b0; // Hold until response taken
            aw_idx <= S_AWADDR_I[7:2];
        end else if (S_BVALID_O && S_BREADY_I) begin
            S_AWREADY_O <= 1'b1;
        end
    end

    // Write data channel, independent of the address order
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_WREADY_O <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_WVALID_I && S_WREADY_O) begin
            S_WREADY_O <= 1'b0;
            w_data <= S_WDATA_I;
            w_strb <= S_WSTRB_I;
        end else if (S_BVALID_O && S_BREADY_I) begin
            S_WREADY_O <= 1'b1;
        end
    end

    // Writable or read-only but known indices answer OKAY
    always_comb begin
        case (aw_idx)
            `PSS_IDX_BASIC_STATUS,
            `PSS_IDX_EXPANSION,
            `PSS_IDX_SUMMARY,
            `PSS_IDX_FALSE_CARRIER,
            `PSS_IDX_RX_ERROR,
            `PSS_IDX_PCS_CONFIG,
            `PSS_IDX_CONTROL_WORD,
            `PSS_IDX_TEN_MEG: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_BVALID_O <= 1'b0;
            S_BRESP_O <= `PSS_RESP_OKAY;
        end else if (wr_fire) begin
            S_BVALID_O <= 1'b1;
            S_BRESP_O <= wr_mapped ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
        end else if (S_BVALID_O && S_BREADY_I) begin
            S_BVALID_O <= 1'b0;
        end
    end

    // Software settings; only byte lane 1 carries these fields
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SD_QUALIFY_O <= `PSS_RST_SD_QUALIFY;
            AUTO_CROSSOVER_ENABLE_O <= `PSS_RST_AUTO_XOVER;
            CROSSOVER_FORCE_O <= `PSS_RST_XOVER_FORCE;
        end else if (wr_fire && w_strb[1]) begin
            if (aw_idx == `PSS_IDX_PCS_CONFIG) begin
                SD_QUALIFY_O <= w_data[`PSS_BIT_SD_QUALIFY];
            end
            if (aw_idx == `PSS_IDX_CONTROL_WORD) begin
                AUTO_CROSSOVER_ENABLE_O <= w_data[`PSS_BIT_AUTO_XOVER];
                CROSSOVER_FORCE_O <= w_data[`PSS_BIT_XOVER_FORCE];
            end
        end
    end

    // Read decode; source words pass through except the ten-meg polarity field, summary built here
    always_comb begin
        next_rdata = 16'h0000;
        next_rresp = `PSS_RESP_OKAY;
        case (rd_idx)
            `PSS_IDX_BASIC_STATUS: next_rdata = BASIC_STATUS_WORD_I;
            `PSS_IDX_EXPANSION: next_rdata = EXPANSION_WORD_I;
            `PSS_IDX_SUMMARY: next_rdata = summary;
            `PSS_IDX_FALSE_CARRIER: next_rdata = FALSE_CARRIER_COUNT_WORD_I;
            `PSS_IDX_RX_ERROR: next_rdata = RX_ERROR_COUNT_WORD_I;
            `PSS_IDX_PCS_CONFIG: begin
                next_rdata[`PSS_BIT_SD_QUALIFY] = SD_QUALIFY_O;
            end
            `PSS_IDX_CONTROL_WORD: begin
                next_rdata[`PSS_BIT_AUTO_XOVER] = AUTO_CROSSOVER_ENABLE_O;
                next_rdata[`PSS_BIT_XOVER_FORCE] = CROSSOVER_FORCE_O;
            end
            `PSS_IDX_TEN_MEG: begin
                // Polarity field comes from the shared latch
                next_rdata = TEN_MEG_STATUS_WORD_I;
                next_rdata[`PSS_BIT_TEN_MEG_POLARITY] = polarity;
            end
            default: next_rresp = `PSS_RESP_SLVERR; // Unmapped reads zero
        endcase
    end

    // Read address and data channels
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_ARREADY_O <= 1'b1;
            S_RVALID_O <= 1'b0;
            S_RDATA_O <= 32'h0000_0000;
            S_RRESP_O <= `PSS_RESP_OKAY;
        end else if (rd_take) begin
            S_ARREADY_O <= 1'b0; // One read at a time
            S_RVALID_O <= 1'b1;
            S_RDATA_O <= {16'h0000, next_rdata};
            S_RRESP_O <= next_rresp;
        end else if (S_RVALID_O && S_RREADY_I) begin
            S_RVALID_O <= 1'b0;
            S_ARREADY_O <= 1'b1;
        end
    end

    // Crossover: manual when auto is off, forced wins when on
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            crossover <= `PSS_RST_STATUS;
        end else if (!AUTO_CROSSOVER_ENABLE_O) begin
            crossover <= CROSSOVER_FORCE_O;
        end else if (CROSSOVER_FORCE_O) begin
            crossover <= 1'b1;
        end else begin
            crossover <= MDIX_SWAP_I;
        end
    end

    // Receive error latch; a new event beats a same-cycle clear
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_error <= `PSS_RST_STATUS;
        end else begin
            rx_error <= RX_ERROR_EVENT_I || (rx_error && !clr_rx_error);
        end
    end

    // Polarity; summary reads deliberately leave it alone
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            polarity <= `PSS_RST_STATUS;
        end else begin
            polarity <= POLARITY_INVERTED_I || (polarity && !clr_ten_meg);
        end
    end

    // False carrier latch
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            false_carrier <= `PSS_RST_STATUS;
        end else begin
            false_carrier <= FALSE_CARRIER_EVENT_I ||
                (false_carrier && !clr_false_carrier);
        end
    end

    // Latch-low detect and lock: a drop wins over the reload read.
    // Both stay zero after reset until the first summary read.
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            signal_detect <= `PSS_RST_STATUS;
            lock <= `PSS_RST_STATUS;
        end else begin
            signal_detect <= sd_qualified && (signal_detect || rd_summary);
            lock <= DESCRAMBLER_LOCK_I && (lock || rd_summary);
        end
    end

    // Page received; only the expansion read clears it
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            page <= `PSS_RST_STATUS;
        end else begin
            page <= PAGE_RECEIVED_EVENT_I || (page && !clr_expansion);
        end
    end

    // Remote fault; cleared by a basic status read or reset
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            remote_fault <= `PSS_RST_STATUS;
        end else begin
            remote_fault <= REMOTE_FAULT_EVENT_I ||
                (remote_fault && !clr_basic);
        end
    end

endmodule
`default_nettype wire

// ### include/pss_map.svh
/*
 Register indices, field positions, reset values and response codes of the
 transceiver status summary block.
 Assumes it is included by bare name; holds definitions only.
*/
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// Register indices; byte address is four times the index
`define PSS_IDX_BASIC_STATUS 6'h01
`define PSS_IDX_EXPANSION 6'h06
`define PSS_IDX_SUMMARY 6'h10
`define PSS_IDX_FALSE_CARRIER 6'h14
`define PSS_IDX_RX_ERROR 6'h15
`define PSS_IDX_PCS_CONFIG 6'h16
`define PSS_IDX_CONTROL_WORD 6'h19
`define PSS_IDX_TEN_MEG 6'h1a

// Summary word field positions
`define PSS_BIT_RSVD_HI 15
`define PSS_BIT_CROSSOVER 14
`define PSS_BIT_RX_ERROR 13
`define PSS_BIT_POLARITY 12
`define PSS_BIT_FALSE_CARRIER 11
`define PSS_BIT_SIGNAL_DETECT 10
`define PSS_BIT_LOCK 9
`define PSS_BIT_PAGE 8
`define PSS_BIT_RSVD_LO 7
`define PSS_BIT_REMOTE_FAULT 6

// Fields of other words
`define PSS_BIT_TEN_MEG_POLARITY 4
`define PSS_BIT_SD_QUALIFY 8
`define PSS_BIT_AUTO_XOVER 15
`define PSS_BIT_XOVER_FORCE 14

// Reset values
`define PSS_RST_STATUS 1'b0
`define PSS_RST_SD_QUALIFY 1'b1
`define PSS_RST_AUTO_XOVER 1'b1
`define PSS_RST_XOVER_FORCE 1'b0

// Bus response codes
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2

`endif

// ### include/pss_pkg.sv
/*
 Types shared by the transceiver status summary block.
 Assumes nothing of its surroundings.
*/
package pss_pkg;
    typedef logic [15:0] pss_word_t; // One management word
    typedef logic [5:0] pss_idx_t; // Register index
    typedef logic [1:0] pss_resp_t; // Bus response code
endpackage

// ### testbench/pss_status_summary_checker.sv
/* Checker for the status summary bank, bound to its top.
 Assumes the summary word is read at byte address 40h. */
`timescale 1ns/10ps
`default_nettype none
module pss_status_summary_checker (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] S_ARADDR_I,
    input wire logic S_ARVALID_I,
    input wire logic S_ARREADY_O,
    input wire logic [31:0] S_RDATA_O,
    input wire logic S_RVALID_O,
    input wire logic S_BVALID_O,
    input wire logic RX_ERROR_EVENT_I,
    input wire logic POLARITY_INVERTED_I,
    input wire logic FALSE_CARRIER_EVENT_I,
    input wire logic PAGE_RECEIVED_EVENT_I,
    input wire logic REMOTE_FAULT_EVENT_I,
    input wire logic CROSSOVER_FORCE_O
);
    // Summary read taken at this edge
    wire logic rs = S_ARVALID_I && S_ARREADY_O && S_ARADDR_I == 8'h40;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    property p_rsv; rs |=> S_RDATA_O[31:15] == 17'h0 && !S_RDATA_O[7]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    // An event seen before the read edge must show in that reply
    property p_rxe; rs && $past(RX_ERROR_EVENT_I) |=> S_RDATA_O[13]; endproperty
    a_rxe: assert property (p_rxe) else $error("rx error lost");
    property p_pol; rs && $past(POLARITY_INVERTED_I) |=> S_RDATA_O[12]; endproperty
    a_pol: assert property (p_pol) else $error("polarity lost");
    property p_fc; rs && $past(FALSE_CARRIER_EVENT_I) |=> S_RDATA_O[11]; endproperty
    a_fc: assert property (p_fc) else $error("false carrier lost");
    property p_pg; rs && $past(PAGE_RECEIVED_EVENT_I) |=> S_RDATA_O[8]; endproperty
    a_pg: assert property (p_pg) else $error("page lost");
    property p_rf; rs && $past(REMOTE_FAULT_EVENT_I) |=> S_RDATA_O[6]; endproperty
    a_rf: assert property (p_rf) else $error("remote fault lost");
    // Force on means swapped whatever the enable
    property p_xo;
        rs && CROSSOVER_FORCE_O && $past(CROSSOVER_FORCE_O) |=> S_RDATA_O[14];
    endproperty
    a_xo: assert property (p_xo) else $error("crossover not swapped");
    // Reply one edge after the address, address side busy meanwhile
    property p_rl; S_ARVALID_I && S_ARREADY_O |=> S_RVALID_O && !S_ARREADY_O; endproperty
    a_rl: assert property (p_rl) else $error("read reply late");
    c_sum: cover property (rs);
    c_xo: cover property (rs ##1 S_RDATA_O[14]);
    c_wr: cover property (S_BVALID_O);
endmodule
bind pss_status_summary pss_status_summary_checker i_chk (.REF_CLK_I, .ARST_N_I, .S_ARADDR_I,
    .S_ARVALID_I, .S_ARREADY_O, .S_RDATA_O, .S_RVALID_O, .S_BVALID_O, .RX_ERROR_EVENT_I,
    .POLARITY_INVERTED_I, .FALSE_CARRIER_EVENT_I, .PAGE_RECEIVED_EVENT_I,
    .REMOTE_FAULT_EVENT_I, .CROSSOVER_FORCE_O);
`default_nettype wire

// ### testbench/pss_mgmt_master.sv
/* Management controller model: AXI4-Lite master with one write and
 one read task; slow mode offers each request a cycle late.
 Assumes one rising-edge clock shared with the slave. */
`timescale 1ns/10ps
`default_nettype none
module pss_mgmt_master (
    input wire logic clk_i,
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    output logic bready_o,
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    output logic rready_o,
    input wire logic awready_i,
    input wire logic wready_i,
    input wire logic bvalid_i,
    input wire logic arready_i,
    input wire logic rvalid_i
);
    logic slow; // Idle one extra cycle before each request
    // Idle bus at time zero
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, slow} = '0;
        wstrb_o = 4'hf; // Every lane enabled
    end
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        if (slow)
            @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= {16'h0, d};
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1; // Held until the response is seen
        do begin
            @(posedge clk_i);
            if (awvalid_o && awready_i) begin
                awvalid_o <= 1'b0;
                awaddr_o <= ~a; // Released lines must not show stale values
            end
            if (wvalid_o && wready_i) begin
                wvalid_o <= 1'b0;
                wdata_o <= ~wdata_o;
            end
        end while (!(bvalid_i && bready_o));
        bready_o <= 1'b0;
    endtask
    // Read: hold the address until taken, then wait for the reply
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        if (slow)
            @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1; // Held until the reply is seen
        do begin
            @(posedge clk_i);
            if (arvalid_o && arready_i) begin
                arvalid_o <= 1'b0;
                araddr_o <= ~a;
            end
        end while (!(rvalid_i && rready_o));
        rready_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_pss_status_summary.sv
/* Bench for the status summary bank: source status is driven here,
 a master model makes bus cycles, replies meet queued notes.
 Assumes the checker binds itself to the block. */
`timescale 1ns/10ps
`default_nettype none
module tb_pss_status_summary;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awa, ara; // Addresses
    logic [31:0] wda, rda; // Data
    logic [3:0] wst;
    logic [1:0] bre, rre; // Reply codes
    logic awv, awr, wv, wr, bv, bok, arv, arr, rv, rok; // Handshakes
    logic mdix, det, lock; // Level sources
    logic [4:0] ev; // Latch-high event sources
    logic [15:0] rw; // Random word of the source units
    logic [33:0] qr[$]; // Expected replies, oldest first
    int bp[5] = '{13, 12, 11, 8, 6}; // Summary bit of each event
    logic [7:0] ca[5] = '{8'h54, 8'h68, 8'h50, 8'h18, 8'h04}; // Its clearing read
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    pss_status_summary i_dut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .S_AWADDR_I(awa),
        .S_AWVALID_I(awv), .S_AWREADY_O(awr), .S_WDATA_I(wda), .S_WSTRB_I(wst), .S_WVALID_I(wv),
        .S_WREADY_O(wr), .S_BRESP_O(bre), .S_BVALID_O(bv), .S_BREADY_I(bok), .S_ARADDR_I(ara),
        .S_ARVALID_I(arv), .S_ARREADY_O(arr), .S_RDATA_O(rda), .S_RRESP_O(rre),
        .S_RVALID_O(rv), .S_RREADY_I(rok), .MDIX_SWAP_I(mdix), .RX_ERROR_EVENT_I(ev[0]),
        .POLARITY_INVERTED_I(ev[1]), .FALSE_CARRIER_EVENT_I(ev[2]), .SIGNAL_DETECT_RAW_I(det),
        .DESCRAMBLER_LOCK_I(lock), .PAGE_RECEIVED_EVENT_I(ev[3]), .REMOTE_FAULT_EVENT_I(ev[4]),
        .BASIC_STATUS_WORD_I(rw), .EXPANSION_WORD_I(rw), .FALSE_CARRIER_COUNT_WORD_I(rw),
        .RX_ERROR_COUNT_WORD_I(rw), .TEN_MEG_STATUS_WORD_I(rw), .AUTO_CROSSOVER_ENABLE_O(),
        .CROSSOVER_FORCE_O(), .SD_QUALIFY_O());
    pss_mgmt_master i_mst (.clk_i(clk), .awaddr_o(awa), .awvalid_o(awv), .wdata_o(wda),
        .wstrb_o(wst), .wvalid_o(wv), .bready_o(bok), .araddr_o(ara), .arvalid_o(arv),
        .rready_o(rok), .awready_i(awr), .wready_i(wr), .bvalid_i(bv), .arready_i(arr),
        .rvalid_i(rv));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Note the reply first, then make the bus cycle
    task automatic rx(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r = 2'h0);
        qr.push_back({r, 16'h0, e});
        i_mst.rd(a);
    endtask
    task automatic wx(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
        qr.push_back({r, 32'h0});
        i_mst.wr(a, d);
    endtask
    // Replies in order against the oldest note; a hang ends the run
    always @(posedge clk) begin
        if (rv && rok)
            chk({rre, rda}, qr.pop_front());
        if (bv && bok)
            chk({bre, 32'h0}, qr.pop_front());
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(19267));
        {mdix, det, lock, ev} = '0;
        rw = 16'($urandom());
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, refused and ignored places
        rx(8'h40, 16'h0000);
        rx(8'h58, 16'h0100);
        rx(8'h64, 16'h8000);
        rx(8'hfc, 16'h0000, 2'h2);
        wx(8'hfc, rw, 2'h2);
        wx(8'h40, ~rw);
        rx(8'h40, 16'h0000);
        // Each latch: set, held past its drop, kept by summary reads, cleared by its own read
        for (int i = 0; i < 5; i++) begin
            ev[i] <= 1'b1;
            rx(8'h40, 16'h1 << bp[i]);
            ev[i] <= 1'b0;
            rx(8'h40, 16'h1 << bp[i]);
            rx(ca[i], i == 1 ? rw | 16'h0010 : rw);
            rx(8'h40, 16'h0000);
        end
        // Crossover under every enable, force and swap, requests offered late
        i_mst.slow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wx(8'h64, {i[2:1], 14'h0});
            mdix <= i[0];
            rx(8'h40, {1'b0, i[1] | i[2] & i[0], 14'h0});
        end
        wx(8'h64, 16'h8000);
        mdix <= 1'b0;
        // Latch-low detect and lock: loaded by a read, a drop held until read
        det <= 1'b1;
        lock <= 1'b1;
        rx(8'h40, 16'h0000);
        rx(8'h40, 16'h0600);
        lock <= 1'b0;
        @(posedge clk);
        lock <= 1'b1;
        rx(8'h40, 16'h0000);
        rx(8'h40, 16'h0600);
        wx(8'h58, 16'h0000); // Qualify off: detect is raw alone
        lock <= 1'b0;
        rx(8'h40, 16'h0400);
        // Remote fault cleared by a reset in mid-run
        ev[4] <= 1'b1;
        @(posedge clk);
        ev[4] <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rx(8'h40, 16'h0000);
        @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
